// ---- rtl/phy_mac_pkg.sv ----
// Shared constants and types for the MAC-facing receive and status block
package phy_mac_pkg;

  localparam int REF_CLK_HZ   = 250_000_000;
  localparam int RX_CLK_HZ_10 = 2_500_000;
  localparam int RX_CLK_HZ_100 = 25_000_000;
  localparam int RX_CLK_HZ_1000 = 125_000_000;
  localparam int HALF_10      = REF_CLK_HZ / (2 * RX_CLK_HZ_10);
  localparam int HALF_100     = REF_CLK_HZ / (2 * RX_CLK_HZ_100);
  localparam int HALF_1000    = REF_CLK_HZ / (2 * RX_CLK_HZ_1000);
  localparam int HALF_W       = 6;

  localparam int BYTE_W       = 8;
  localparam int WORD_W       = BYTE_W + 1;
  localparam int ERR_BIT      = BYTE_W;
  localparam int FIFO_DEPTH   = 8;
  localparam int SYNC_STAGES  = 3;

  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic       RST_LEVEL = 1'b0;

  typedef enum logic [1:0] {
    MODE_MII   = 2'h0,
    MODE_GMII  = 2'h1,
    MODE_RGMII = 2'h2
  } mode_e;

  typedef enum logic [1:0] {
    SPD_10   = 2'h0,
    SPD_100  = 2'h1,
    SPD_1000 = 2'h2
  } speed_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOW  = 2'h1,
    ST_HIGH = 2'h3
  } beat_state_e;

endpackage : phy_mac_pkg

// ---- rtl/rx_word_if.sv ----
// Valid/ready word stream between the FIFO and the receive sequencer
interface rx_word_if #(
  parameter int WIDTH = 9
) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : rx_word_if

// ---- rtl/rx_word_fifo.sv ----
// Receive word FIFO with valid and ready on both sides
module rx_word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  input  wire logic             i_clk_en,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  rx_word_if.src                o_out
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("FIFO depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  always_comb begin
    full  = (wr_ptr[AW] != rd_ptr[AW]) &&
            (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    empty = (wr_ptr == rd_ptr);
    push  = i_in_valid && !full && i_clk_en;
    pop   = o_out.valid && o_out.ready && i_clk_en;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  assign o_in_ready  = !full && i_clk_en;
  assign o_out.valid = !empty;
  assign o_out.data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (i_clk_en) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
endmodule : rx_word_fifo

// ---- rtl/link_sampler.sv ----
// Three-stage sampler and edge finder for the transmit clock and control
module link_sampler (
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic i_clk_en,
  input  wire logic i_link_clk,
  input  wire logic i_link_ctrl,
  output logic      o_rise,
  output logic      o_fall,
  output logic      o_ctrl
);
  localparam int N = phy_mac_pkg::SYNC_STAGES;

  logic [N-1:0] clk_sync;
  logic [N-1:0] ctrl_sync;
  logic         clk_filt;
  logic         next_clk_filt;
  logic         next_ctrl;
  logic         next_rise;
  logic         next_fall;

  always_comb begin
    next_clk_filt = (clk_sync[1] == clk_sync[2]) ? clk_sync[2] : clk_filt;
    next_ctrl     = (ctrl_sync[1] == ctrl_sync[2]) ? ctrl_sync[2] : o_ctrl;
    next_rise     = next_clk_filt && !clk_filt;
    next_fall     = !next_clk_filt && clk_filt;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      clk_sync  <= '0;
      ctrl_sync <= '0;
      clk_filt  <= phy_mac_pkg::RST_LEVEL;
      o_ctrl    <= phy_mac_pkg::RST_LEVEL;
      o_rise    <= phy_mac_pkg::RST_LEVEL;
      o_fall    <= phy_mac_pkg::RST_LEVEL;
    end else if (i_clk_en) begin
      clk_sync  <= {clk_sync[N-2:0], i_link_clk};
      ctrl_sync <= {ctrl_sync[N-2:0], i_link_ctrl};
      clk_filt  <= next_clk_filt;
      o_ctrl    <= next_ctrl;
      o_rise    <= next_rise;
      o_fall    <= next_fall;
    end
  end
endmodule : link_sampler

// ---- rtl/phy_mac_rx_status.sv ----
// PHY side of the MAC receive path, control lines and status outputs

// Summary of operation
// - Receive data bits 0 to 3 driven in every mode, timed by the receive clock.
// - Receive data bits 4 to 7 carry the upper byte half in GMII only.
// - In RGMII transmit control carries enable and error on both edges.
// - Data valid high while valid data sits on the nibble or byte lanes.
// - In RGMII receive control carries valid and error on both edges.
// - Receive error raised with the receive clock on a detected error.
// - The separate receive error output stays unused in RGMII.
// - Half duplex raises collision on simultaneous transmit and receive.
// - Full duplex holds collision low.
// - Collision output unused in RGMII.
// - Half duplex raises carrier sense on receive or transmit activity.
// - Full duplex 10/100 carrier sense follows receive only; gigabit low.
// - Carrier sense output unused in RGMII.
// - Receive clock is 2.5, 25 or 125 MHz by speed.
module phy_mac_rx_status #(
  parameter int DEPTH = phy_mac_pkg::FIFO_DEPTH
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic       i_clk_en,
  input  wire logic [1:0] i_mode,
  input  wire logic [1:0] i_speed,
  input  wire logic       i_full_duplex,
  input  wire logic       i_rx_activity,
  input  wire logic [7:0] i_rx_byte,
  input  wire logic       i_rx_byte_err,
  input  wire logic       i_rx_byte_valid,
  output logic            o_rx_byte_ready,
  input  wire logic       i_gtx_clk,
  input  wire logic       i_tx_ctrl,
  output logic            o_rx_clk,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_ctrl,
  output logic            o_rx_er,
  output logic            o_col,
  output logic            o_crs,
  output logic            o_tx_enable,
  output logic            o_tx_error
);
  localparam int HW = phy_mac_pkg::HALF_W;

  if (phy_mac_pkg::HALF_10 >= (1 << HW) || DEPTH < 2) begin : g_chk
    $error("Divider width or FIFO depth cannot serve these settings");
  end

  function automatic logic [3:0] pick_nibble(input logic [7:0] b,
                                             input logic       hi);
    pick_nibble = hi ? b[7:4] : b[3:0];
  endfunction : pick_nibble

  rx_word_if #(.WIDTH(phy_mac_pkg::WORD_W)) fifo_out ();

  rx_word_fifo #(
    .WIDTH (phy_mac_pkg::WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_in_data  ({i_rx_byte_err, i_rx_byte}),
    .i_in_valid (i_rx_byte_valid),
    .o_in_ready (o_rx_byte_ready),
    .o_out      (fifo_out)
  );

  logic link_rise;
  logic link_fall;
  logic link_ctrl;

  link_sampler u_link (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_clk_en    (i_clk_en),
    .i_link_clk  (i_gtx_clk),
    .i_link_ctrl (i_tx_ctrl),
    .o_rise      (link_rise),
    .o_fall      (link_fall),
    .o_ctrl      (link_ctrl)
  );

  logic                     is_mii;
  logic                     is_gmii;
  logic                     is_rgmii;
  logic                     is_gig;
  logic                     nibble_mode;
  logic [HW-1:0]            half_cnt;
  logic [HW-1:0]            next_half_cnt;
  logic [HW-1:0]            half_limit;
  logic                     toggle;
  logic                     rise_beat;
  logic                     fall_beat;
  logic                     load;
  logic                     nib_beat;
  logic                     next_rx_clk;
  phy_mac_pkg::beat_state_e state;
  phy_mac_pkg::beat_state_e next_state;
  logic [7:0]               cur_byte;
  logic [7:0]               next_cur_byte;
  logic                     cur_err;
  logic                     next_cur_err;
  logic [7:0]               next_rx_data;
  logic                     next_rx_ctrl;
  logic                     next_rx_er;
  logic                     next_col;
  logic                     next_crs;
  logic                     tx_en_sample;
  logic                     next_tx_en_sample;
  logic                     next_tx_enable;
  logic                     next_tx_error;

  always_comb begin
    is_mii      = (i_mode == phy_mac_pkg::MODE_MII);
    is_gmii     = (i_mode == phy_mac_pkg::MODE_GMII);
    is_rgmii    = (i_mode == phy_mac_pkg::MODE_RGMII);
    is_gig      = (i_speed == phy_mac_pkg::SPD_1000);
    nibble_mode = is_mii || (is_rgmii && !is_gig);
    case (i_speed)
      phy_mac_pkg::SPD_1000: half_limit = HW'(phy_mac_pkg::HALF_1000);
      phy_mac_pkg::SPD_100:  half_limit = HW'(phy_mac_pkg::HALF_100);
      default:               half_limit = HW'(phy_mac_pkg::HALF_10);
    endcase
  end

  // Receive clock divider
  always_comb begin
    toggle        = (half_cnt >= half_limit - 1'b1);
    next_half_cnt = toggle ? '0 : half_cnt + 1'b1;
    next_rx_clk   = toggle ? !o_rx_clk : o_rx_clk;
    rise_beat     = toggle && !o_rx_clk;
    fall_beat     = toggle && o_rx_clk;
    load     = (is_rgmii ? rise_beat : fall_beat) &&
               (!nibble_mode || state != phy_mac_pkg::ST_LOW);
    nib_beat = nibble_mode && (state == phy_mac_pkg::ST_LOW) &&
               (is_rgmii ? rise_beat : fall_beat);
    fifo_out.ready = load && i_clk_en;
  end

  // Receive sequencer and output lanes
  always_comb begin
    next_state    = state;
    next_cur_byte = cur_byte;
    next_cur_err  = cur_err;
    next_rx_data  = o_rx_data;
    next_rx_ctrl  = o_rx_ctrl;
    next_rx_er    = o_rx_er;
    if (load) begin
      if (fifo_out.valid) begin
        next_cur_byte = fifo_out.data[7:0];
        next_cur_err  = fifo_out.data[phy_mac_pkg::ERR_BIT];
        next_state    = phy_mac_pkg::ST_LOW;
      end else begin
        next_cur_byte = phy_mac_pkg::RST_BYTE;
        next_cur_err  = phy_mac_pkg::RST_LEVEL;
        next_state    = phy_mac_pkg::ST_IDLE;
      end
    end else if (nib_beat) begin
      next_state = phy_mac_pkg::ST_HIGH;
    end
    if (load || nib_beat) begin
      if (nibble_mode || is_rgmii) begin
        next_rx_data = {4'h0, pick_nibble(next_cur_byte,
                        next_state == phy_mac_pkg::ST_HIGH)};
      end else begin
        next_rx_data = next_cur_byte;
      end
      next_rx_ctrl = (next_state != phy_mac_pkg::ST_IDLE);
      next_rx_er   = next_rx_ctrl && next_cur_err;
    end else if (is_rgmii && fall_beat) begin
      if (is_gig) begin
        next_rx_data = {4'h0, pick_nibble(cur_byte, 1'b1)};
      end
      next_rx_ctrl = (state != phy_mac_pkg::ST_IDLE) ^ cur_err;
    end
    if (!is_gmii) begin
      next_rx_data[7:4] = 4'h0;
    end
    if (is_rgmii) begin
      next_rx_er = phy_mac_pkg::RST_LEVEL;
    end
  end

  // Collision and carrier sense
  always_comb begin
    next_col = !i_full_duplex && !is_rgmii &&
               i_rx_activity && o_tx_enable;
    if (is_rgmii) begin
      next_crs = phy_mac_pkg::RST_LEVEL;
    end else if (!i_full_duplex) begin
      next_crs = i_rx_activity || o_tx_enable;
    end else begin
      next_crs = !is_gig && i_rx_activity;
    end
  end

  // Transmit enable and error decode
  always_comb begin
    next_tx_en_sample = tx_en_sample;
    next_tx_enable    = o_tx_enable;
    next_tx_error     = o_tx_error;
    if (link_rise) begin
      if (is_rgmii) begin
        next_tx_en_sample = link_ctrl;
      end else begin
        next_tx_enable = link_ctrl;
        next_tx_error  = phy_mac_pkg::RST_LEVEL;
      end
    end else if (link_fall && is_rgmii) begin
      next_tx_enable = tx_en_sample;
      next_tx_error  = tx_en_sample ^ link_ctrl;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      half_cnt     <= '0;
      o_rx_clk     <= phy_mac_pkg::RST_LEVEL;
      state        <= phy_mac_pkg::ST_IDLE;
      cur_byte     <= phy_mac_pkg::RST_BYTE;
      cur_err      <= phy_mac_pkg::RST_LEVEL;
      o_rx_data    <= phy_mac_pkg::RST_BYTE;
      o_rx_ctrl    <= phy_mac_pkg::RST_LEVEL;
      o_rx_er      <= phy_mac_pkg::RST_LEVEL;
      o_col        <= phy_mac_pkg::RST_LEVEL;
      o_crs        <= phy_mac_pkg::RST_LEVEL;
      tx_en_sample <= phy_mac_pkg::RST_LEVEL;
      o_tx_enable  <= phy_mac_pkg::RST_LEVEL;
      o_tx_error   <= phy_mac_pkg::RST_LEVEL;
    end else if (i_clk_en) begin
      half_cnt     <= next_half_cnt;
      o_rx_clk     <= next_rx_clk;
      state        <= next_state;
      cur_byte     <= next_cur_byte;
      cur_err      <= next_cur_err;
      o_rx_data    <= next_rx_data;
      o_rx_ctrl    <= next_rx_ctrl;
      o_rx_er      <= next_rx_er;
      o_col        <= next_col;
      o_crs        <= next_crs;
      tx_en_sample <= next_tx_en_sample;
      o_tx_enable  <= next_tx_enable;
      o_tx_error   <= next_tx_error;
    end
  end

  property p_gmii_byte;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_clk_en && is_gmii && fifo_out.ready && fifo_out.valid)
      |=> (o_rx_data == $past(fifo_out.data[7:0])) && o_rx_ctrl;
  endproperty
  a_gmii_byte: assert property (p_gmii_byte)
    else $error("GMII byte not presented after pop");

  property p_upper_zero;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_clk_en && !is_gmii) |=> (o_rx_data[7:4] == 4'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("Upper data bits driven outside GMII");

  property p_idle_no_valid;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_clk_en && !is_rgmii && load && !fifo_out.valid)
      |=> !o_rx_ctrl && !o_rx_er;
  endproperty
  a_idle_no_valid: assert property (p_idle_no_valid)
    else $error("Data valid raised with no word to send");

  property p_rgmii_fall;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_clk_en && is_rgmii && fall_beat)
      |=> o_rx_ctrl == (($past(state) != phy_mac_pkg::ST_IDLE) ^
                        $past(cur_err));
  endproperty
  a_rgmii_fall: assert property (p_rgmii_fall)
    else $error("RGMII falling control sample wrong");

  property p_er_rgmii;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_clk_en && is_rgmii) |=> !o_rx_er;
  endproperty
  a_er_rgmii: assert property (p_er_rgmii)
    else $error("Receive error driven in RGMII");

  property p_col_half;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_clk_en && !i_full_duplex && !is_rgmii)
      |=> o_col == ($past(i_rx_activity) && $past(o_tx_enable));
  endproperty
  a_col_half: assert property (p_col_half)
    else $error("Collision does not match activity");

  property p_col_low;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_clk_en && (i_full_duplex || is_rgmii)) |=> !o_col;
  endproperty
  a_col_low: assert property (p_col_low)
    else $error("Collision high in full duplex or RGMII");

  property p_crs;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_clk_en && !is_rgmii && i_rx_activity && !(i_full_duplex && is_gig))
      |=> o_crs;
  endproperty
  a_crs: assert property (p_crs)
    else $error("Carrier sense missing during receive");

  property p_crs_fd;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_clk_en && i_full_duplex && !i_rx_activity) |=> !o_crs;
  endproperty
  a_crs_fd: assert property (p_crs_fd)
    else $error("Full duplex carrier sense without receive");

  property p_gig_clk;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_clk_en && is_gig) |=> (o_rx_clk != $past(o_rx_clk));
  endproperty
  a_gig_clk: assert property (p_gig_clk)
    else $error("Gigabit receive clock not toggling each cycle");

  property p_tx_rgmii;
    @(posedge i_ref_clk) disable iff (i_reset)
      (i_clk_en && is_rgmii && link_fall && !link_rise)
      |=> o_tx_error == ($past(tx_en_sample) ^ $past(link_ctrl));
  endproperty
  a_tx_rgmii: assert property (p_tx_rgmii)
    else $error("RGMII transmit error decode wrong");
endmodule : phy_mac_rx_status

// ---- dv/mac_model.sv ----
// MAC partner: transmit clock and control, receive lane capture
module mac_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rx_clk,
  input  wire logic [7:0] i_rx_data,
  input  wire logic       i_rx_ctrl,
  input  wire logic       i_rx_er,
  input  wire logic       i_tx_en,
  input  wire logic       i_tx_err,
  input  wire logic       i_rgmii,
  output logic            o_gtx_clk,
  output logic            o_tx_ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [18:0] cap_q [$];
  logic        prev_clk = 1'b0;
  logic [9:0]  rise_s   = '0;
  // Free-running transmit clock, control moved mid-phase
  initial begin
    o_gtx_clk = 1'b0;
    o_tx_ctrl = 1'b0;
    forever begin
      #16 o_tx_ctrl = i_tx_en;
      #16 o_gtx_clk = 1'b1;
      #16 o_tx_ctrl = i_rgmii ? (i_tx_en ^ i_tx_err) : i_tx_en;
      #16 o_gtx_clk = 1'b0;
    end
  end
  // Rising sample paired with the following falling sample
  always @(posedge i_ref_clk) begin
    prev_clk <= i_rx_clk;
    if (i_rx_clk && !prev_clk) begin
      rise_s <= {i_rx_er, i_rx_ctrl, i_rx_data};
    end
    if (!i_rx_clk && prev_clk && rise_s[8]) begin
      cap_q.push_back({rise_s, i_rx_ctrl, i_rx_data});
    end
  end
endmodule : mac_model

// ---- dv/test_phy_mac_rx_status.sv ----
// Testbench for the MAC-facing receive and status block
module test_phy_mac_rx_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk, reset, clk_en, full_duplex, rx_activity;
  logic [1:0] mode, speed;
  logic [7:0] rx_byte, rx_data;
  logic       rx_byte_err, rx_byte_valid, rx_byte_ready, gtx_clk, tx_ctrl;
  logic       rx_clk, rx_ctrl, rx_er, col, crs, tx_enable, tx_error;
  logic       tx_en, tx_err;
  int         fail_count, n_tests, cycles;

  phy_mac_rx_status u_phy_mac_rx_status (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_clk_en(clk_en),
    .i_mode(mode), .i_speed(speed), .i_full_duplex(full_duplex),
    .i_rx_activity(rx_activity), .i_rx_byte(rx_byte),
    .i_rx_byte_err(rx_byte_err), .i_rx_byte_valid(rx_byte_valid),
    .o_rx_byte_ready(rx_byte_ready), .i_gtx_clk(gtx_clk),
    .i_tx_ctrl(tx_ctrl), .o_rx_clk(rx_clk), .o_rx_data(rx_data),
    .o_rx_ctrl(rx_ctrl), .o_rx_er(rx_er), .o_col(col), .o_crs(crs),
    .o_tx_enable(tx_enable), .o_tx_error(tx_error)
  );
  mac_model u_mac_model (
    .i_ref_clk(ref_clk), .i_rx_clk(rx_clk), .i_rx_data(rx_data),
    .i_rx_ctrl(rx_ctrl), .i_rx_er(rx_er), .i_tx_en(tx_en),
    .i_tx_err(tx_err), .i_rgmii(mode == phy_mac_pkg::MODE_RGMII),
    .o_gtx_clk(gtx_clk), .o_tx_ctrl(tx_ctrl)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("ERROR at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  task chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task cfg(input logic [1:0] m, input logic [1:0] s);
    @(posedge ref_clk);
    mode  <= m;
    speed <= s;
    repeat (250) @(posedge ref_clk);
    u_mac_model.cap_q.delete();
  endtask : cfg

  task send(input logic [8:0] b [$], output int waits);
    waits = 0;
    foreach (b[i]) begin
      rx_byte       <= b[i][7:0];
      rx_byte_err   <= b[i][8];
      rx_byte_valid <= 1'b1;
      do begin
        @(posedge ref_clk);
        waits++;
      end while (rx_byte_ready !== 1'b1);
    end
    rx_byte_valid <= 1'b0;
  endtask : send

  task wait_caps(input int n);
    for (int k = 0; k < 3000 && u_mac_model.cap_q.size() < n; k++) begin
      @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
    chk(12'(u_mac_model.cap_q.size()), 12'(n));
  endtask : wait_caps

  task expect_rise(input logic [8:0] e [$]);
    logic [18:0] c;
    wait_caps(e.size());
    foreach (e[i]) begin
      c = u_mac_model.cap_q[i];
      chk(12'({c[18], c[16:9]}), 12'(e[i]));
    end
  endtask : expect_rise

  task t_gmii();
    int w;
    cfg(phy_mac_pkg::MODE_GMII, phy_mac_pkg::SPD_1000);
    send('{9'h0AA, 9'h15C, 9'h0F3}, w);
    expect_rise('{9'h0AA, 9'h15C, 9'h0F3});
  endtask : t_gmii

  task t_mii();
    int w;
    cfg(phy_mac_pkg::MODE_MII, phy_mac_pkg::SPD_100);
    send('{9'h03C, 9'h1A7}, w);
    expect_rise('{9'h00C, 9'h003, 9'h107, 9'h10A});
  endtask : t_mii

  task t_rgmii();
    int          w;
    logic [18:0] c;
    logic [11:0] e;
    logic [11:0] ex [6];
    ex = '{12'h369, 12'h2B4, 12'h366, 12'h399, 12'h2BB, 12'h244};
    for (int r = 0; r < 2; r++) begin
      cfg(phy_mac_pkg::MODE_RGMII,
          r == 0 ? phy_mac_pkg::SPD_1000 : phy_mac_pkg::SPD_100);
      send('{9'h096, 9'h14B}, w);
      wait_caps(2 + 2 * r);
      for (int k = 0; k < 2 + 2 * r; k++) begin
        c = u_mac_model.cap_q[k];
        e = ex[2 * r + k];
        chk({1'b0, c[18], c[17], c[8], c[12:9], c[3:0]}, e);
      end
    end
  endtask : t_rgmii

  task t_rate();
    realtime t0;
    int      per;
    logic    lvl;
    for (int s = 0; s < 3; s++) begin
      cfg(phy_mac_pkg::MODE_GMII, 2'(s));
      @(posedge rx_clk);
      t0 = $realtime;
      @(posedge rx_clk);
      per = int'(($realtime - t0) / 4.0);
      chk(12'(per), 12'(s == 0 ? 100 : s == 1 ? 10 : 2));
    end
    @(posedge ref_clk);
    clk_en <= 1'b0;
    @(posedge ref_clk);
    lvl = rx_clk;
    repeat (3) @(posedge ref_clk);
    chk(12'(rx_clk), 12'(lvl));
    clk_en <= 1'b1;
  endtask : t_rate

  task t_fifo();
    int         w;
    logic [8:0] q [$];
    for (int i = 0; i < 12; i++) begin
      q.push_back(9'(8'h10 + i));
    end
    cfg(phy_mac_pkg::MODE_GMII, phy_mac_pkg::SPD_10);
    send(q, w);
    chk(12'(w > 12), 12'h001);
    expect_rise(q);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    @(posedge ref_clk);
    chk(12'(rx_byte_ready), 12'h000);
    clk_en <= 1'b1;
  endtask : t_fifo

  task t_status();
    logic exp_col, exp_crs, exp_err;
    for (int m = 0; m < 3; m++) begin
      for (int d = 0; d < 2; d++) begin
        for (int s = 0; s < 3; s++) begin
          for (int v = 0; v < 4; v++) begin
            @(posedge ref_clk);
            mode        <= 2'(m);
            full_duplex <= d[0];
            speed       <= 2'(s);
            tx_en       <= v[1];
            tx_err      <= v[0];
            rx_activity <= v[0];
            repeat (40) @(posedge ref_clk);
            exp_col = !d[0] && m != 2 && v[1] && v[0];
            exp_crs = (m != 2) && (d[0] ? (s != 2 && v[0]) : (v[1] | v[0]));
            exp_err = (m == 2) && v[0];
            chk(12'(col), 12'(exp_col));
            chk(12'(crs), 12'(exp_crs));
            chk(12'({tx_enable, tx_error}), 12'({v[1], exp_err}));
          end
        end
      end
    end
  endtask : t_status

  initial begin
    reset         = 1'b1;
    clk_en        = 1'b1;
    mode          = phy_mac_pkg::MODE_GMII;
    speed         = phy_mac_pkg::SPD_1000;
    full_duplex   = 1'b1;
    rx_activity   = 1'b0;
    rx_byte       = 8'h00;
    rx_byte_err   = 1'b0;
    rx_byte_valid = 1'b0;
    tx_en         = 1'b0;
    tx_err        = 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({rx_data, rx_ctrl, rx_er, col, crs}, 12'h000);
    reset <= 1'b0;
    t_status();
    t_gmii();
    t_mii();
    t_rgmii();
    t_rate();
    t_fifo();
    print_verdict();
  end
endmodule : test_phy_mac_rx_status
